// ===== spi_host_pkg.sv
// shared constants for the host serial port status and access block
// assumes byte wide registers on a 16-bit register address port
package spi_host_pkg;

    // register offsets
    localparam logic [15:0] SECURITY_OFS    = 16'h00B2;
    localparam logic [15:0] COMMAND_OFS     = 16'h00FD;
    localparam logic [15:0] STATUS_OFS      = 16'h2708;
    localparam logic [15:0] CONTROL_OFS     = 16'h270C;

    // field positions
    localparam int          PROTECT_BIT     = 6;
    localparam int          PORT_EN_BIT     = 4;
    localparam int          SAFE_BIT        = 3;
    localparam int          FLASH_PROG_BIT  = 0;
    localparam int          ST_READY_ERR    = 7;
    localparam int          ST_RD_PAR       = 6;
    localparam int          ST_WR_PAR       = 5;
    localparam int          ST_CNT_HI       = 4;
    localparam int          ST_CNT_LO       = 2;
    localparam int          ST_FLASH_MODE   = 1;
    localparam int          ST_FLASH_RDY    = 0;
    localparam int          FLASH_SEL_BIT   = 15;
    localparam int          PAGE_HI         = 14;
    localparam int          PAGE_LO         = 10;

    // reset values
    localparam logic        PROTECT_RST     = 1'b0;
    localparam logic        PORT_EN_RST     = 1'b1;
    localparam logic        SAFE_RST        = 1'b0;
    localparam logic        FLASH_PROG_RST  = 1'b0;
    localparam logic [7:0]  STATUS_RST      = 8'h00;
    localparam logic [7:0]  COMMAND_RST     = 8'h00;

    // host command codes
    localparam logic [7:0]  CMD_READ        = 8'h01;
    localparam logic [7:0]  CMD_WRITE       = 8'h02;
    localparam logic [7:0]  CMD_ERASE       = 8'h03;

    // framing, counts and safe-mode window
    localparam logic [7:0]  HEADER_BYTES    = 8'h03;
    localparam logic [7:0]  COUNT_MAX       = 8'hFF;
    localparam logic [2:0]  SHORT_COUNT     = 3'h7;
    localparam logic [15:0] SAFE_BASE       = 16'h0400;
    localparam logic [15:0] SAFE_SIZE       = 16'h0010;

endpackage : spi_host_pkg

// ===== spi_link_if.sv
// signals between the core and the serial-clock shifter
// shifter side on the host serial clock, core on ref_clk
`timescale 1ns/1ps
interface spi_link_if;
    logic [7:0] rx_byte;
    logic       half_byte;
    logic [7:0] tx_byte;
    logic       frame_n;

    modport link (
        output rx_byte,
        output half_byte,
        input  tx_byte,
        input  frame_n
    );
    modport core (
        input  rx_byte,
        input  half_byte,
        output tx_byte,
        output frame_n
    );
endinterface : spi_link_if

// ===== spi_link_shifter.sv
// bit shifter clocked by the host serial clock, msb first, mode 0
// assumes the host clock idles low and stands still outside frames
`timescale 1ns/1ps
module spi_link_shifter (
    input  wire logic   sclk,
    input  wire logic   serial_in,
    output logic        serial_out,
    spi_link_if.link    lk
);
    logic [2:0] rcnt_q;
    logic [6:0] rsh_q;
    logic [7:0] rx_q;
    logic [2:0] tcnt_q;
    logic [7:0] tsh_q;

    // frame end clears counters; the clock may not tick again
    always_ff @(posedge sclk or posedge lk.frame_n) begin
        if (lk.frame_n) begin
            rcnt_q <= 3'h0;
            rsh_q  <= 7'h00;
        end else begin
            rcnt_q <= rcnt_q + 3'h1;
            rsh_q  <= {rsh_q[5:0], serial_in};
        end
    end

    // held a whole byte, long after the core samples it
    always_ff @(posedge sclk) begin
        if (!lk.frame_n && rcnt_q == 3'h7) begin
            rx_q <= {rsh_q, serial_in};
        end
    end

    always_ff @(negedge sclk or posedge lk.frame_n) begin
        if (lk.frame_n) begin
            tcnt_q <= 3'h0;
            tsh_q  <= 8'h00;
        end else begin
            if (tcnt_q == 3'h0) begin
                tsh_q <= {lk.tx_byte[6:0], 1'b0};
            end else begin
                tsh_q <= {tsh_q[6:0], 1'b0};
            end
            tcnt_q <= tcnt_q + 3'h1;
        end
    end

    // rises mid byte, falls at byte end: two events
    assign lk.half_byte = rcnt_q[2];
    assign lk.rx_byte   = rx_q;
    assign serial_out   = (tcnt_q == 3'h0) ? lk.tx_byte[7] : tsh_q[7];

endmodule : spi_link_shifter

// ===== spi_host_port.sv
// host serial port: access control, command capture, transaction status
// assumes byte memory answering a cycle after mem_re, flash on ref_clk
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

// Notes on behaviour
// R1: status bits 7:2 updated only at transaction end, bits 1:0 live
// R2: bit 7 flags access not ready
// R3: bit 6 parity of data bytes sent
// R4: bit 5 parity of all bytes received
// R5: bits 4:2 data count, short gives 111
// R6: bit 1 flash mode, zero without test
// R7: bit 0 flash ready for next write
// R8: command byte readable by processor
// R9: port enable gates pins, set at reset
// R10: safe mode limits writes to window
// R11: protect bit blocks external flash reads
// R12: protect bit refuses page zero, engine erase
// R13: parity is xor accumulated, latched at end
module spi_host_port (
    input  wire logic          ref_clk,
    input  wire logic          srst,
    input  wire logic          clk_en,
    input  wire logic          serial_clock_pin,
    input  wire logic          serial_in_pin,
    input  wire logic          chip_select_pin_n,
    output logic               serial_out_pin,
    output logic               serial_out_oe,
    input  wire logic          test_mode_pin,
    input  wire logic          flash_ready_in,
    input  wire logic [5:0]    engine_code_start,
    output logic [15:0]        mem_addr,
    output logic [7:0]         mem_wdata,
    output logic               mem_we,
    output logic               mem_re,
    input  wire logic [7:0]    mem_rdata,
    input  wire logic          mem_ready,
    output logic               flash_erase,
    output logic [4:0]         flash_erase_page,
    output logic               debug_read_block,
    input  wire logic [15:0]   reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_we,
    input  wire logic          reg_re,
    output logic [7:0]         reg_rdata
);

    typedef enum logic [1:0] {
        PH_CMD,
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_DATA
    } phase_type;

    spi_link_if lk ();

    logic               protect_q;
    logic               port_en_q;
    logic               safe_q;
    logic               flash_prog_q;
    logic [7:0]         command_q;
    logic [7:0]         status_q;
    logic [7:0]         reg_rdata_q;

    logic               fr_s1_q;
    logic               fr_s2_q;
    logic               fr_s3_q;
    logic               hb_s1_q;
    logic               hb_s2_q;
    logic               hb_s3_q;
    logic               tm_s1_q;
    logic               tm_s2_q;

    phase_type          phase_q;
    logic [15:0]        addr_q;
    logic [7:0]         nbytes_q;
    logic               wpar_q;
    logic               rpar_q;
    logic               err_q;
    logic [7:0]         tx_q;
    logic [7:0]         pend_q;
    logic               rd_cap_q;
    logic [15:0]        mem_addr_q;
    logic [7:0]         mem_wdata_q;
    logic               mem_we_q;
    logic               mem_re_q;
    logic               erase_q;
    logic [4:0]         erase_page_q;

    logic               frame_end;
    logic               frame_idle;
    logic               byte_ev;
    logic               mid_ev;
    logic               flash_mode;
    logic               flash_rdy;
    logic [7:0]         data_cnt;
    logic [2:0]         cnt_field;
    logic [7:0]         status_rd;
    logic [7:0]         status_next;
    logic [7:0]         sec_rd;
    logic [7:0]         ctl_rd;
    logic [15:0]        rd_target;
    logic               rd_blocked;
    logic               in_window;
    logic               write_ok;
    logic [15:0]        erase_addr;
    logic [4:0]         erase_page;
    logic               erase_ok;

    spi_link_shifter u_shifter (
        .sclk       (serial_clock_pin),
        .serial_in  (serial_in_pin),
        .serial_out (serial_out_pin),
        .lk         (lk)
    );

    // a disabled port looks like a host that never selects us
    assign lk.frame_n    = chip_select_pin_n | ~port_en_q;  // R9
    assign lk.tx_byte    = tx_q;
    assign serial_out_oe = ~lk.frame_n;  // R9

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fr_s1_q <= 1'b1;
            fr_s2_q <= 1'b1;
            fr_s3_q <= 1'b1;
            hb_s1_q <= 1'b0;
            hb_s2_q <= 1'b0;
            hb_s3_q <= 1'b0;
            tm_s1_q <= 1'b0;
            tm_s2_q <= 1'b0;
        end else if (clk_en) begin
            fr_s1_q <= lk.frame_n;
            fr_s2_q <= fr_s1_q;
            fr_s3_q <= fr_s2_q;
            hb_s1_q <= lk.half_byte;
            hb_s2_q <= hb_s1_q;
            hb_s3_q <= hb_s2_q;
            tm_s1_q <= test_mode_pin;
            tm_s2_q <= tm_s1_q;
        end
    end

    assign frame_end  = fr_s2_q & ~fr_s3_q;
    assign frame_idle = fr_s2_q;
    assign mid_ev     = hb_s2_q & ~hb_s3_q;
    assign byte_ev    = ~hb_s2_q & hb_s3_q;

    // live bits; a low test pin forces flash mode off
    assign flash_mode = tm_s2_q & flash_prog_q;  // R6
    assign flash_rdy  = flash_mode & flash_ready_in;  // R7

    assign data_cnt  = nbytes_q - spi_host_pkg::HEADER_BYTES;
    assign cnt_field = (nbytes_q <= spi_host_pkg::HEADER_BYTES) ?
                       spi_host_pkg::SHORT_COUNT : data_cnt[2:0];  // R5

    always_comb begin
        status_next = spi_host_pkg::STATUS_RST;
        status_next[spi_host_pkg::ST_READY_ERR] = err_q;  // R2
        status_next[spi_host_pkg::ST_RD_PAR]    = rpar_q;  // R3
        status_next[spi_host_pkg::ST_WR_PAR]    = wpar_q;  // R4
        status_next[spi_host_pkg::ST_CNT_HI:spi_host_pkg::ST_CNT_LO] =
            cnt_field;  // R5
    end

    always_comb begin
        status_rd = status_q;
        status_rd[spi_host_pkg::ST_FLASH_MODE] = flash_mode;  // R6
        status_rd[spi_host_pkg::ST_FLASH_RDY]  = flash_rdy;  // R7
    end

    // later reads run a byte ahead so the shifter never waits
    assign rd_target  = (phase_q == PH_ADDR_LO) ?
                        {addr_q[15:8], lk.rx_byte} : addr_q + 16'h0001;
    assign rd_blocked = protect_q & rd_target[spi_host_pkg::FLASH_SEL_BIT];
    assign in_window  = (addr_q >= spi_host_pkg::SAFE_BASE) &&
                        (addr_q - spi_host_pkg::SAFE_BASE <
                         spi_host_pkg::SAFE_SIZE);
    assign write_ok   = ~safe_q | in_window;  // R10

    assign erase_addr = {addr_q[15:8], lk.rx_byte};
    assign erase_page =
        erase_addr[spi_host_pkg::PAGE_HI:spi_host_pkg::PAGE_LO];
    assign erase_ok   = ~protect_q ||
                        (erase_page != 5'h00 &&
                         {1'b0, erase_page} < engine_code_start);  // R12

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            phase_q      <= PH_CMD;
            addr_q       <= 16'h0000;
            nbytes_q     <= 8'h00;
            wpar_q       <= 1'b0;
            rpar_q       <= 1'b0;
            err_q        <= 1'b0;
            tx_q         <= spi_host_pkg::STATUS_RST;
            pend_q       <= 8'h00;
            rd_cap_q     <= 1'b0;
            mem_addr_q   <= 16'h0000;
            mem_wdata_q  <= 8'h00;
            mem_we_q     <= 1'b0;
            mem_re_q     <= 1'b0;
            erase_q      <= 1'b0;
            erase_page_q <= 5'h00;
            command_q    <= spi_host_pkg::COMMAND_RST;
        end else if (clk_en) begin
            mem_we_q <= 1'b0;
            mem_re_q <= 1'b0;
            erase_q  <= 1'b0;
            rd_cap_q <= mem_re_q;
            if (rd_cap_q) begin
                pend_q <= mem_rdata;
            end
            if (frame_end) begin
                phase_q  <= PH_CMD;
                nbytes_q <= 8'h00;
                wpar_q   <= 1'b0;
                rpar_q   <= 1'b0;
                err_q    <= 1'b0;
            end else if (byte_ev) begin
                wpar_q <= wpar_q ^ (^lk.rx_byte);  // R13
                if (nbytes_q != spi_host_pkg::COUNT_MAX) begin
                    nbytes_q <= nbytes_q + 8'h01;
                end
                case (phase_q)
                    PH_CMD: begin
                        command_q <= lk.rx_byte;  // R8
                        phase_q   <= PH_ADDR_HI;
                    end
                    PH_ADDR_HI: begin
                        addr_q[15:8] <= lk.rx_byte;
                        phase_q      <= PH_ADDR_LO;
                    end
                    PH_ADDR_LO: begin
                        addr_q  <= {addr_q[15:8], lk.rx_byte};
                        phase_q <= PH_DATA;
                        if (command_q == spi_host_pkg::CMD_READ) begin
                            if (rd_blocked) begin
                                pend_q <= 8'h00;  // R11
                            end else if (!mem_ready) begin
                                err_q  <= 1'b1;  // R2
                                pend_q <= 8'h00;
                            end else begin
                                mem_re_q   <= 1'b1;
                                mem_addr_q <= rd_target;
                            end
                        end
                        if (command_q == spi_host_pkg::CMD_ERASE &&
                            erase_ok) begin
                            erase_q      <= 1'b1;  // R12
                            erase_page_q <= erase_page;
                        end
                    end
                    PH_DATA: begin
                        if (command_q == spi_host_pkg::CMD_WRITE) begin
                            addr_q <= addr_q + 16'h0001;
                            if (write_ok && mem_ready) begin
                                mem_we_q    <= 1'b1;  // R10
                                mem_addr_q  <= addr_q;
                                mem_wdata_q <= lk.rx_byte;
                            end else if (write_ok) begin
                                err_q <= 1'b1;  // R2
                            end
                        end
                    end
                    default: begin
                        phase_q <= PH_CMD;
                    end
                endcase
            end else if (mid_ev) begin
                // mid byte is far from the shifter's load point
                if (phase_q == PH_DATA &&
                    command_q == spi_host_pkg::CMD_READ) begin
                    tx_q   <= pend_q;
                    rpar_q <= rpar_q ^ (^tx_q);  // R3 R13
                    addr_q <= addr_q + 16'h0001;
                    if (rd_blocked) begin
                        pend_q <= 8'h00;  // R11
                    end else if (!mem_ready) begin
                        err_q  <= 1'b1;  // R2
                        pend_q <= 8'h00;
                    end else begin
                        mem_re_q   <= 1'b1;
                        mem_addr_q <= rd_target;
                    end
                end else begin
                    tx_q <= 8'h00;
                end
            end else if (frame_idle) begin
                // status goes out first in every frame
                tx_q <= status_rd;
            end
        end
    end

    // empty frames leave the status alone
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_q <= spi_host_pkg::STATUS_RST;
        end else if (clk_en) begin
            if (frame_end && nbytes_q != 8'h00) begin
                status_q <= status_next;  // R1
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            protect_q    <= spi_host_pkg::PROTECT_RST;
            port_en_q    <= spi_host_pkg::PORT_EN_RST;  // R9
            safe_q       <= spi_host_pkg::SAFE_RST;
            flash_prog_q <= spi_host_pkg::FLASH_PROG_RST;
        end else if (clk_en && reg_we) begin
            if (reg_addr == spi_host_pkg::SECURITY_OFS) begin
                protect_q <= reg_wdata[spi_host_pkg::PROTECT_BIT];
            end else if (reg_addr == spi_host_pkg::CONTROL_OFS) begin
                port_en_q    <= reg_wdata[spi_host_pkg::PORT_EN_BIT];
                safe_q       <= reg_wdata[spi_host_pkg::SAFE_BIT];
                flash_prog_q <= reg_wdata[spi_host_pkg::FLASH_PROG_BIT];
            end
        end
    end

    always_comb begin
        sec_rd = 8'h00;
        sec_rd[spi_host_pkg::PROTECT_BIT] = protect_q;
        ctl_rd = 8'h00;
        ctl_rd[spi_host_pkg::PORT_EN_BIT]    = port_en_q;
        ctl_rd[spi_host_pkg::SAFE_BIT]       = safe_q;
        ctl_rd[spi_host_pkg::FLASH_PROG_BIT] = flash_prog_q;
    end

    // read data stand one cycle, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata_q <= 8'h00;
        end else if (clk_en) begin
            if (!reg_re) begin
                reg_rdata_q <= 8'h00;
            end else if (reg_addr == spi_host_pkg::SECURITY_OFS) begin
                reg_rdata_q <= sec_rd;
            end else if (reg_addr == spi_host_pkg::COMMAND_OFS) begin
                reg_rdata_q <= command_q;  // R8
            end else if (reg_addr == spi_host_pkg::STATUS_OFS) begin
                reg_rdata_q <= status_rd;  // R1
            end else if (reg_addr == spi_host_pkg::CONTROL_OFS) begin
                reg_rdata_q <= ctl_rd;
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

    assign reg_rdata        = reg_rdata_q;
    assign mem_addr         = mem_addr_q;
    assign mem_wdata        = mem_wdata_q;
    assign mem_we           = mem_we_q;
    assign mem_re           = mem_re_q;
    assign flash_erase      = erase_q;
    assign flash_erase_page = erase_page_q;
    assign debug_read_block = protect_q;  // R11

endmodule : spi_host_port

// ===== spi_host_port_assertions.sv
// checker for spi_host_port, bound to its ports
// assumes every pin is sampled on ref_clk and clk_en is held high
`timescale 1ns/1ps
module spi_host_port_chk (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        chip_select_pin_n,
    input wire logic        serial_out_oe,
    input wire logic        test_mode_pin,
    input wire logic [5:0]  engine_code_start,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_we,
    input wire logic        mem_re,
    input wire logic        flash_erase,
    input wire logic [4:0]  flash_erase_page,
    input wire logic        debug_read_block,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_re,
    input wire logic [7:0]  reg_rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence status_read;
        reg_re && reg_addr == spi_host_pkg::STATUS_OFS;
    endsequence
    // five cycles cover both sync stages and the read
    sequence test_low;
        !test_mode_pin [*5];
    endsequence
    a_oe_needs_cs: assert property (
        serial_out_oe |-> !chip_select_pin_n) else $error("oe outside frame");
    a_rd_idle_zero: assert property (
        !$past(reg_re) |-> reg_rdata == 8'h00) else $error("stray read data");
    a_we_one_pulse: assert property (
        mem_we |=> !mem_we) else $error("long write pulse");
    a_erase_one_pulse: assert property (
        flash_erase |=> !flash_erase) else $error("long erase pulse");
    a_erase_not_zero: assert property (
        flash_erase && debug_read_block |-> flash_erase_page != 5'h00)
        else $error("page zero erased");
    a_erase_below_engine: assert property (
        flash_erase && debug_read_block
        |-> {1'b0, flash_erase_page} < engine_code_start)
        else $error("engine code erased");
    a_protect_no_flash: assert property (
        mem_re && debug_read_block |-> !mem_addr[15])
        else $error("protected flash read");
    a_mode_off_test: assert property (
        test_low ##0 status_read |=> reg_rdata[1:0] == 2'b00)
        else $error("flash mode without test");
    a_ready_needs_mode: assert property (
        status_read |=> !reg_rdata[0] || reg_rdata[1])
        else $error("ready outside flash mode");
endmodule : spi_host_port_chk

bind spi_host_port spi_host_port_chk u_chk (
    .ref_clk, .srst, .chip_select_pin_n, .serial_out_oe, .test_mode_pin,
    .engine_code_start, .mem_addr, .mem_we, .mem_re, .flash_erase,
    .flash_erase_page, .debug_read_block, .reg_addr, .reg_re, .reg_rdata
);

// ===== spi_host_model.sv
// host master of the serial link, one frame per call
// assumes mode 0, msb first, 32 ns serial period, clock idle low
`timescale 1ns/1ps
module spi_host_model (
    output logic      serial_clock_pin,
    output logic      serial_in_pin,
    output logic      chip_select_pin_n,
    input  wire logic serial_out_pin
);
    initial begin
        serial_clock_pin = 1'b0;
        serial_in_pin = 1'b1;
        chip_select_pin_n = 1'b1;
    end
    // n bytes from the top of tx; rx bytes land alike
    task automatic frame(input int n, input logic [63:0] tx,
                         output logic [63:0] rx);
        rx = '0;
        chip_select_pin_n = 1'b0;
        for (int i = 0; i < 8 * n; i++) begin
            serial_in_pin = tx[63 - i];
            #16 serial_clock_pin = 1'b1;
            rx[63 - i] = serial_out_pin;
            #16 serial_clock_pin = 1'b0;
        end
        // clock still; select held a period past the last edge
        #32 chip_select_pin_n = 1'b1;
        // no pull: released line shows its last bit inverted
        serial_in_pin = ~serial_in_pin;
        #100;
    endtask : frame
endmodule : spi_host_model

// ===== tb.sv
// bench for spi_host_port: register table, then host frames
// assumes spi_host_model and a byte memory stub
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic        we;
        logic [15:0] a;
        logic [7:0]  v;
    } row_type;
    localparam logic [15:0] SC = spi_host_pkg::SECURITY_OFS;
    localparam logic [15:0] CM = spi_host_pkg::COMMAND_OFS;
    localparam logic [15:0] ST = spi_host_pkg::STATUS_OFS;
    localparam logic [15:0] CT = spi_host_pkg::CONTROL_OFS;
    localparam row_type     ROWS [15] = '{
        '{1'b0, SC, 8'h00}, '{1'b0, CM, 8'h00}, '{1'b0, ST, 8'h00},
        '{1'b0, CT, 8'h10}, '{1'b0, 16'h1234, 8'h00}, '{1'b1, ST, 8'hFF},
        '{1'b0, ST, 8'h00}, '{1'b1, CM, 8'hAA}, '{1'b0, CM, 8'h00},
        '{1'b1, CT, 8'h19}, '{1'b0, CT, 8'h19}, '{1'b1, CT, 8'h10},
        '{1'b1, SC, 8'h40}, '{1'b0, SC, 8'h40}, '{1'b1, SC, 8'h00}};
    logic        ref_clk, srst, test_mode_pin, flash_ready_in, mem_ready;
    logic        serial_clock_pin, serial_in_pin, chip_select_pin_n;
    logic        serial_out_pin, serial_out_oe, mem_we, mem_re, seen_oe;
    logic        flash_erase, debug_read_block, reg_we, reg_re;
    logic [15:0] reg_addr, mem_addr, wa;
    logic [7:0]  reg_wdata, reg_rdata, mem_rdata, mem_wdata, wd, d;
    logic [7:0]  n_wr, n_er, n_rd, k;
    logic [4:0]  flash_erase_page;
    logic [63:0] rx;
    int          err_total = 0;
    int          n_compared = 0;

    spi_host_port dut (
        .ref_clk, .srst, .clk_en(1'b1), .serial_clock_pin, .serial_in_pin,
        .chip_select_pin_n, .serial_out_pin, .serial_out_oe, .test_mode_pin,
        .flash_ready_in, .engine_code_start(6'h08), .mem_addr, .mem_wdata,
        .mem_we, .mem_re, .mem_rdata, .mem_ready, .flash_erase,
        .flash_erase_page, .debug_read_block, .reg_addr, .reg_wdata,
        .reg_we, .reg_re, .reg_rdata);
    spi_host_model host (
        .serial_clock_pin, .serial_in_pin, .chip_select_pin_n,
        .serial_out_pin);

    // read data track the address
    always @(posedge ref_clk) begin
        mem_rdata <= mem_addr[7:0] + 8'h11;
        if (mem_we) {n_wr, wa, wd} <= {n_wr + 8'h01, mem_addr, mem_wdata};
        if (mem_re) n_rd <= n_rd + 8'h01;
        if (flash_erase) n_er <= n_er + 8'h01;
        if (serial_out_oe) seen_oe <= 1'b1;
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] st(logic e, rp, wp, logic [2:0] c);
        return {e, rp, wp, c, 2'b00};
    endfunction : st
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        {reg_we, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        {reg_re, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_re <= 1'b0;
        #1 v = reg_rdata;
    endtask : reg_rd
    // odd start keeps pin edges off clock edges
    task automatic frm(input int n, input logic [63:0] tx);
        @(posedge ref_clk);
        #3 seen_oe = 1'b0;
        host.frame(n, tx, rx);
        repeat (8) @(posedge ref_clk);
    endtask : frm
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    initial begin
        {srst, mem_ready, test_mode_pin, flash_ready_in} = 4'hC;
        {reg_we, reg_re, reg_addr, reg_wdata, seen_oe} = '0;
        {n_wr, n_er, n_rd} = '0;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].we) reg_wr(ROWS[i].a, ROWS[i].v);
            else begin
                reg_rd(ROWS[i].a, d);
                check(d, ROWS[i].v);
            end
        end
        $display("done: registers");
        frm(4, 64'h020400A5_00000000);
        check({rx[63:56], seen_oe, n_wr}, 17'h00101);
        check({wa, wd}, 24'h0400A5);
        reg_rd(ST, d);
        check(d, st(0, 0, ^32'h020400A5, 3'h1));
        reg_rd(CM, d);
        check(d, 8'h02);
        $display("done: write");
        reg_wr(CT, 8'h18);
        frm(4, 64'h02050011_00000000);
        frm(4, 64'h02040F5A_00000000);
        frm(4, 64'h02041066_00000000);
        check({n_wr, wa, wd}, 32'h02040F5A);
        reg_wr(CT, 8'h10);
        $display("done: safe mode");
        reg_wr(SC, 8'h40);
        frm(6, 64'h01001000_00000000);
        check(rx[63:56], st(0, 0, ^32'h02041066, 3'h1));
        check(rx[31:16], 16'h2122);
        reg_rd(ST, d);
        check(d, st(0, ^16'h2122, ^32'h01001000, 3'h3));
        k = n_rd;
        frm(6, 64'h01800000_00000000);
        check({rx[31:16], n_rd, debug_read_block}, {16'h0, k, 1'b1});
        $display("done: protected read");
        frm(3, 64'h03000000_00000000);
        frm(3, 64'h03200000_00000000);
        frm(3, 64'h030C0000_00000000);
        check({n_er, flash_erase_page}, {8'h01, 5'h03});
        reg_wr(SC, 8'h00);
        frm(3, 64'h03000000_00000000);
        check({n_er, flash_erase_page}, {8'h02, 5'h00});
        $display("done: erase");
        frm(1, 64'h55000000_00000000);
        reg_rd(CM, d);
        check(d, 8'h55);
        reg_rd(ST, d);
        check(d, st(0, 0, ^8'h55, 3'h7));
        @(posedge ref_clk) mem_ready <= 1'b0;
        k = n_wr;
        frm(4, 64'h02040077_00000000);
        reg_rd(ST, d);
        check({d, n_wr}, {st(1, 0, ^32'h02040077, 3'h1), k});
        @(posedge ref_clk) mem_ready <= 1'b1;
        $display("done: short and not ready");
        @(posedge ref_clk) {test_mode_pin, flash_ready_in} <= 2'b11;
        reg_wr(CT, 8'h11);
        repeat (4) @(posedge ref_clk);
        reg_rd(ST, d);
        check(d[1:0], 2'b11);
        @(posedge ref_clk) flash_ready_in <= 1'b0;
        reg_rd(ST, d);
        check(d[1:0], 2'b10);
        @(posedge ref_clk) test_mode_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reg_rd(ST, d);
        check(d[1:0], 2'b00);
        $display("done: flash mode");
        reg_wr(CT, 8'h00);
        k = n_wr;
        frm(4, 64'h02040133_00000000);
        check({seen_oe, n_wr}, {1'b0, k});
        @(posedge ref_clk) srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        reg_rd(ST, d);
        check(d, 8'h00);
        reg_rd(CT, d);
        check(d, 8'h10);
        $display("done: disable and reset");
        close_out();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
endmodule : tb
